// >>> verilog/imr_pkg.sv
// Constants for the page-zero status and output register set.
// Assumes a 40 MHz core clock and a frame decoder that hands over 16-bit words.
package imr_pkg;
	// ************************************************************
	// Register offsets (byte addresses within a page)
	// ************************************************************
	localparam logic [6:0]  ADDR_PAGE_LO = 7'h00;
	localparam logic [6:0]  ADDR_PAGE_HI = 7'h01;
	localparam logic [6:0]  ADDR_CNT     = 7'h04;
	localparam logic [6:0]  ADDR_ERR     = 7'h08;
	localparam logic [6:0]  ADDR_DIAG    = 7'h0a;
	localparam logic [6:0]  ADDR_TEMP    = 7'h0e;
	localparam logic [6:0]  ADDR_GXL     = 7'h10;
	localparam logic [6:0]  ADDR_GXH     = 7'h12;
	localparam logic [6:0]  ADDR_GYL     = 7'h14;
	localparam logic [6:0]  ADDR_GYH     = 7'h16;

	// ************************************************************
	// Reset values and masks
	// ************************************************************
	localparam logic [15:0] PAGE_RST     = 16'h0000;
	localparam logic [15:0] PAGE_USER    = 16'h0000;
	localparam logic [15:0] CNT_RST      = 16'h0000;
	localparam logic [15:0] WORD_ZERO    = 16'h0000;
	localparam logic [15:0] CNT_STEP     = 16'h0001;
	localparam logic [15:0] ERR_USED     = 16'h81ee;
	localparam logic [15:0] ERR_KEEP     = 16'h0080;
	localparam logic [15:0] DIAG_USED    = 16'h003f;
	localparam logic [15:0] DIAG_KEEP    = 16'h0000;

	// ************************************************************
	// Error word and function control bit positions
	// ************************************************************
	localparam int          ERR_WDT      = 15;
	localparam int          ERR_SYNC     = 8;
	localparam int          ERR_OVR      = 7;
	localparam int          ERR_FLASH    = 6;
	localparam int          ERR_SELF     = 5;
	localparam int          ERR_SPI      = 3;
	localparam int          ERR_SRAM     = 2;
	localparam int          ERR_BOOT     = 1;
	localparam int          FNC_PULSE_SYNC = 8;

	// ************************************************************
	// Frame layout and timing
	// ************************************************************
	localparam int          FRM_WRITE    = 15;
	localparam int          FRM_ADDR_MSB = 14;
	localparam int          FRM_ADDR_LSB = 8;
	localparam logic [7:0]  SCLK_FRACT   = 8'h0f;
	localparam int          CLK_HZ       = 40_000_000;
	localparam int          CRC_PERIOD_MS = 20;
	localparam int          CRC_PERIOD_CYC = CLK_HZ / 1000 * CRC_PERIOD_MS;
endpackage : imr_pkg

// >>> verilog/imr_flag_if.sv
// Carrier between the register top and a read-to-clear flag word.
// Assumes one clock; set and clear are sampled every edge.
`timescale 1ns/1ps
interface imr_flag_if #(
	parameter int W = 16
);
	logic [W-1:0] set;
	logic         clr;
	logic [W-1:0] value;

	modport owner (input set, input clr, output value);
	modport user  (output set, output clr, input value);
endinterface : imr_flag_if

// >>> verilog/imr_flags.sv
// Sticky flag word, cleared by a read strobe except for kept bits.
// Assumes set holds current conditions; a set in the clearing cycle wins.
`timescale 1ns/1ps
module imr_flags
	import imr_pkg::*;
#(
	parameter int          W    = 16,
	parameter logic [15:0] USED = ERR_USED,
	parameter logic [15:0] KEEP = ERR_KEEP
) (
	input  wire logic   clk,
	input  wire logic   rst,
	imr_flag_if.owner   f
);
	typedef struct packed {
		logic [W-1:0] flags;
	} imr_flag_s;

	imr_flag_s s_reg;
	imr_flag_s s_next;

	always_comb begin
		s_next = s_reg;
		if (f.clr) begin
			s_next.flags = s_reg.flags & KEEP[W-1:0];
		end
		// Set after clear: a condition still present re-arms its bit
		s_next.flags = (s_next.flags | f.set) & USED[W-1:0];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign f.value = s_reg.flags;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_set_wins_clear: assert property (
		(f.set & USED[W-1:0]) != '0 |=> (f.value & $past(f.set & USED[W-1:0]))
			== $past(f.set & USED[W-1:0]))
		else $error("flag set lost");
	a_read_clears_word: assert property (
		f.clr && f.set == '0 |=> f.value == ($past(f.value) & KEEP[W-1:0]))
		else $error("read did not clear flags");
	a_unused_zero: assert property (
		(f.value & ~USED[W-1:0]) == '0)
		else $error("unused flag bit set");
endmodule : imr_flags

// >>> verilog/imr_regs.sv
// Page-zero status and sensor output registers of the motion module.
// Assumes a frame decoder delivering whole 16-bit words with their clock
// count, and a sensor core delivering samples and fault conditions.
`timescale 1ns/1ps
module imr_regs
	import imr_pkg::*;
#(
	parameter int CRC_PERIOD_CYCLES = CRC_PERIOD_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        frame_valid,
	input  wire logic [15:0] frame_word,
	input  wire logic [7:0]  frame_sclk_cnt,
	input  wire logic        sample_update,
	input  wire logic [31:0] gyro_x,
	input  wire logic [31:0] gyro_y,
	input  wire logic [15:0] temp_in,
	input  wire logic [15:0] io_function_control,
	input  wire logic        wdt_reset_evt,
	input  wire logic        sync_fault,
	input  wire logic        overrun_evt,
	input  wire logic        flash_update_done,
	input  wire logic        flash_update_ok,
	input  wire logic        self_test_done,
	input  wire logic        self_test_fail,
	input  wire logic [5:0]  diag_fail,
	input  wire logic        crc_check_done,
	input  wire logic        crc_check_fail,
	input  wire logic        boot_crc_bad,
	output logic      [15:0] rd_data,
	output logic             rd_valid,
	output logic      [15:0] page_select,
	output logic             crc_check_start,
	output logic             boot_from_backup
);
	localparam int TW = $clog2(CRC_PERIOD_CYCLES + 1);
	localparam logic [TW-1:0] TMR_LAST = TW'(CRC_PERIOD_CYCLES - 1);
	localparam logic [TW-1:0] TMR_ONE  = TW'(1);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [15:0]   page;
		logic [15:0]   cnt;
		logic [15:0]   temp;
		logic [31:0]   gx;
		logic [31:0]   gy;
		logic [15:0]   rdata;
		logic          rvalid;
		logic [TW-1:0] tmr;
		logic          crc_start;
		logic          backup;
	} imr_regs_s;

	imr_regs_s s_reg;
	imr_regs_s s_next;

	imr_flag_if #(.W(16)) err_if ();
	imr_flag_if #(.W(16)) diag_if ();

	imr_flags #(.W(16), .USED(ERR_USED), .KEEP(ERR_KEEP)) u_err (
		.clk (clk),
		.rst (rst),
		.f   (err_if)
	);

	imr_flags #(.W(16), .USED(DIAG_USED), .KEEP(DIAG_KEEP)) u_diag (
		.clk (clk),
		.rst (rst),
		.f   (diag_if)
	);

	// ************************************************************
	// Frame decode
	// ************************************************************
	logic       frame_ok;
	logic       frame_bad;
	logic       is_write;
	logic [6:0] faddr;
	logic       on_user_page;

	assign frame_ok     = frame_valid && (frame_sclk_cnt & SCLK_FRACT) == '0;
	assign frame_bad    = frame_valid && (frame_sclk_cnt & SCLK_FRACT) != '0;
	assign is_write     = frame_word[FRM_WRITE];
	assign faddr        = frame_word[FRM_ADDR_MSB:FRM_ADDR_LSB];
	assign on_user_page = s_reg.page == PAGE_USER;

	// Word address: the low address bit only picks the byte on writes
	function automatic logic addr_hit(input logic [6:0] a,
			input logic [6:0] target);
		addr_hit = {a[6:1], 1'b0} == target;
	endfunction : addr_hit

	function automatic logic [15:0] rd_mux(input imr_regs_s s,
			input logic [6:0] a, input logic user, input logic [15:0] err,
			input logic [15:0] diag);
		rd_mux = WORD_ZERO;
		if (addr_hit(a, ADDR_PAGE_LO)) begin
			rd_mux = s.page;
		end else if (!user) begin
			rd_mux = WORD_ZERO;
		end else if (addr_hit(a, ADDR_CNT)) begin
			rd_mux = s.cnt;
		end else if (addr_hit(a, ADDR_ERR)) begin
			rd_mux = err;
		end else if (addr_hit(a, ADDR_DIAG)) begin
			rd_mux = diag;
		end else if (addr_hit(a, ADDR_TEMP)) begin
			rd_mux = s.temp;
		end else if (addr_hit(a, ADDR_GXL)) begin
			rd_mux = s.gx[15:0];
		end else if (addr_hit(a, ADDR_GXH)) begin
			rd_mux = s.gx[31:16];
		end else if (addr_hit(a, ADDR_GYL)) begin
			rd_mux = s.gy[15:0];
		end else if (addr_hit(a, ADDR_GYH)) begin
			rd_mux = s.gy[31:16];
		end
	endfunction : rd_mux

	// ************************************************************
	// Flag sources
	// ************************************************************
	always_comb begin
		err_if.set = '0;
		err_if.set[ERR_WDT]   = wdt_reset_evt;
		err_if.set[ERR_SYNC]  = sync_fault
			&& io_function_control[FNC_PULSE_SYNC];
		err_if.set[ERR_OVR]   = overrun_evt;
		err_if.set[ERR_FLASH] = flash_update_done
			&& !flash_update_ok;
		err_if.set[ERR_SELF]  = self_test_done && self_test_fail;
		err_if.set[ERR_SPI]   = frame_bad;
		err_if.set[ERR_SRAM]  = crc_check_done && crc_check_fail;
		err_if.set[ERR_BOOT]  = boot_crc_bad;
		err_if.clr = frame_ok && !is_write && on_user_page
			&& addr_hit(faddr, ADDR_ERR);
		diag_if.set = {10'h000, diag_fail};
		diag_if.clr = frame_ok && !is_write && on_user_page
			&& addr_hit(faddr, ADDR_DIAG);
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		s_next = s_reg;
		s_next.rvalid = 1'b0;
		s_next.crc_start = 1'b0;
		// Malformed frames only raise the SPI error flag; the host is expected to retry
		if (frame_ok && is_write) begin
			if (faddr == ADDR_PAGE_LO) begin
				s_next.page[7:0] = frame_word[7:0];
			end else if (faddr == ADDR_PAGE_HI) begin
				s_next.page[15:8] = frame_word[7:0];
			end
		end else if (frame_ok) begin
			s_next.rdata = rd_mux(s_reg, faddr, on_user_page,
				err_if.value, diag_if.value);
			s_next.rvalid = 1'b1;
		end
		if (sample_update) begin
			s_next.cnt = s_reg.cnt + CNT_STEP;
			s_next.temp = temp_in;
			s_next.gx = gyro_x;
			s_next.gy = gyro_y;
		end
		if (s_reg.tmr == TMR_LAST) begin
			s_next.tmr = '0;
			s_next.crc_start = 1'b1;
		end else begin
			s_next.tmr = s_reg.tmr + TMR_ONE;
		end
		// Backup boot is latched until the next reset
		if (boot_crc_bad) begin
			s_next.backup = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.page <= PAGE_RST;
			s_reg.cnt <= CNT_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rd_data          = s_reg.rdata;
	assign rd_valid         = s_reg.rvalid;
	assign page_select      = s_reg.page;
	assign crc_check_start  = s_reg.crc_start;
	assign boot_from_backup = s_reg.backup;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_page_write_lo: assert property (
		frame_ok && is_write && faddr == ADDR_PAGE_LO
			|=> page_select[7:0] == $past(frame_word[7:0]))
		else $error("page write lost");
	a_count_step: assert property (
		sample_update |=> s_reg.cnt == 16'($past(s_reg.cnt) + CNT_STEP))
		else $error("counter did not step");
	a_count_hold: assert property (
		!sample_update |=> $stable(s_reg.cnt))
		else $error("counter moved without update");
	a_wdt_flag: assert property (
		wdt_reset_evt |=> err_if.value[ERR_WDT])
		else $error("watchdog flag missing");
	a_sync_gated: assert property (
		!err_if.value[ERR_SYNC] && !io_function_control[FNC_PULSE_SYNC]
			|=> !err_if.value[ERR_SYNC])
		else $error("sync flag outside sync mode");
	a_overrun_kept: assert property (
		err_if.value[ERR_OVR] |=> err_if.value[ERR_OVR])
		else $error("overrun flag cleared");
	a_spi_flag: assert property (
		frame_bad |=> err_if.value[ERR_SPI] && $stable(page_select))
		else $error("framing error not flagged");
	a_crc_spacing: assert property (
		crc_check_start |=> !crc_check_start)
		else $error("crc start too close");
	a_read_data: assert property (
		frame_ok && !is_write && on_user_page && addr_hit(faddr, ADDR_ERR)
			|=> rd_valid && rd_data == $past(err_if.value))
		else $error("error word read wrong");
	a_rate_split: assert property (
		frame_ok && !is_write && on_user_page && addr_hit(faddr, ADDR_GXH)
			|=> rd_data == $past(s_reg.gx[31:16]))
		else $error("rate high word wrong");
	a_page_write_hi: assert property (
		frame_ok && is_write && faddr == ADDR_PAGE_HI
			|=> page_select[15:8] == $past(frame_word[7:0]))
		else $error("page high write lost");
	a_page_read: assert property (
		frame_ok && !is_write && addr_hit(faddr, ADDR_PAGE_LO)
			|=> rd_valid && rd_data == $past(page_select))
		else $error("page read wrong");
	// Other pages are not modelled; no page-zero data may leak there
	a_other_page_zero: assert property (
		frame_ok && !is_write && !on_user_page
			&& !addr_hit(faddr, ADDR_PAGE_LO) |=> rd_data == WORD_ZERO)
		else $error("foreign page read not zero");
	a_bad_frame_quiet: assert property (
		frame_bad |=> !rd_valid)
		else $error("bad frame answered");
	a_sync_flag: assert property (
		sync_fault && io_function_control[FNC_PULSE_SYNC]
			|=> err_if.value[ERR_SYNC])
		else $error("sync flag missing");
	a_flash_flag: assert property (
		flash_update_done && !flash_update_ok |=> err_if.value[ERR_FLASH])
		else $error("flash flag missing");
	a_self_flag: assert property (
		self_test_done && self_test_fail |=> err_if.value[ERR_SELF])
		else $error("self test flag missing");
	a_sram_flag: assert property (
		crc_check_done && crc_check_fail |=> err_if.value[ERR_SRAM])
		else $error("memory crc flag missing");
	// Timer free-runs; a start pulse must come in the same cycle as every wrap
	a_crc_timer: assert property (
		s_reg.tmr == TMR_LAST |=> crc_check_start && s_reg.tmr == '0)
		else $error("crc period wrong");
	// Backup boot only ends with a reset, so it must never drop
	a_boot_latch: assert property (
		boot_crc_bad |=> boot_from_backup && err_if.value[ERR_BOOT])
		else $error("backup boot not latched");
	a_boot_sticky: assert property (
		boot_from_backup |=> boot_from_backup)
		else $error("backup boot dropped");
	a_sample_load: assert property (
		sample_update |=> s_reg.temp == $past(temp_in)
			&& s_reg.gx == $past(gyro_x) && s_reg.gy == $past(gyro_y))
		else $error("sample not loaded");
	a_diag_read: assert property (
		frame_ok && !is_write && on_user_page
			&& addr_hit(faddr, ADDR_DIAG)
			|=> rd_valid && rd_data == $past(diag_if.value))
		else $error("self-test word read wrong");
endmodule : imr_regs

// >>> tb/imr_host.sv
// Host-side frame source standing in for the serial master.
// Assumes a frame decoder in between; frames change at the falling edge.
`timescale 1ns/1ps
module imr_host (
	input  wire logic   clk,
	output logic        frame_valid,
	output logic [15:0] frame_word,
	output logic [7:0]  frame_sclk_cnt
);
	initial begin
		frame_valid = 1'b0;
		frame_word = 16'h0000;
		frame_sclk_cnt = 8'h10;
	end

	// Frames carry the clock count asked for; any multiple of 16 is a whole frame
	task automatic send(input logic [15:0] w, input logic [7:0] n);
		@(negedge clk);
		frame_valid = 1'b1;
		frame_word = w;
		frame_sclk_cnt = n;
		@(negedge clk);
		frame_valid = 1'b0;
		// Idle bus shows the inverse so stale data never looks valid
		frame_word = ~w;
	endtask : send
endmodule : imr_host

// >>> tb/tb.sv
// Self-checking bench for the page-zero status and output registers.
// Assumes the host model and the register block; no sensor core present.
`timescale 1ns/1ps
module tb;
	import imr_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        sample_update = 1'b0;
	logic [31:0] gyro_x = 32'h0;
	logic [31:0] gyro_y = 32'h0;
	logic [15:0] temp_in = 16'h0;
	logic [15:0] io_function_control = 16'h0;
	logic [9:0]  ev = 10'h000;
	logic [5:0]  diag_fail = 6'h00;
	logic        frame_valid;
	logic [15:0] frame_word;
	logic [7:0]  frame_sclk_cnt;
	logic [15:0] rd_data;
	logic        rd_valid;
	logic [15:0] page_select;
	logic        crc_check_start;
	logic        boot_from_backup;
	int          miscompares = 0;
	int          checked = 0;
	int          cycles = 0;
	int          n;

	always #12.5 clk = ~clk;

	imr_host host (.clk(clk), .frame_valid(frame_valid),
		.frame_word(frame_word), .frame_sclk_cnt(frame_sclk_cnt));

	imr_regs #(.CRC_PERIOD_CYCLES(50)) uut (.clk(clk), .rst(rst),
		.frame_valid(frame_valid), .frame_word(frame_word),
		.frame_sclk_cnt(frame_sclk_cnt), .sample_update(sample_update),
		.gyro_x(gyro_x), .gyro_y(gyro_y), .temp_in(temp_in),
		.io_function_control(io_function_control),
		.wdt_reset_evt(ev[0]), .sync_fault(ev[1]), .overrun_evt(ev[2]),
		.flash_update_done(ev[3]), .flash_update_ok(ev[4]),
		.self_test_done(ev[5]), .self_test_fail(ev[6]),
		.diag_fail(diag_fail), .crc_check_done(ev[7]),
		.crc_check_fail(ev[8]), .boot_crc_bad(ev[9]),
		.rd_data(rd_data), .rd_valid(rd_valid), .page_select(page_select),
		.crc_check_start(crc_check_start),
		.boot_from_backup(boot_from_backup));

	// ****************************************
	// Shared checks and bus cycles
	// ****************************************
	task automatic results;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results

	always @(posedge clk) begin
		cycles++;
		// Wrap test alone takes about 66k cycles
		if (cycles > 80000) begin
			miscompares++;
			results();
		end
	end

	task automatic chk(input string s, input logic [31:0] x,
		input logic [31:0] g);
		checked++;
		if (g !== x) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", s, x, g);
		end
	endtask : chk

	task automatic rd(input logic [6:0] a, input logic [15:0] x);
		host.send({1'b0, a, 8'h00}, 8'h10);
		chk("rd_valid", 32'h1, {31'h0, rd_valid});
		chk($sformatf("reg %h", a), {16'h0, x}, {16'h0, rd_data});
	endtask : rd

	task automatic e(input logic [9:0] p, input logic [15:0] io,
		input logic [15:0] x);
		@(negedge clk);
		io_function_control = io;
		ev = p;
		@(negedge clk);
		ev = 10'h000;
		rd(ADDR_ERR, x);
		rd(ADDR_ERR, x & 16'h0080);
	endtask : e

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		chk("page", 32'h0, {16'h0, page_select});
		rd(ADDR_CNT, 16'h0000);
		rd(ADDR_ERR, 16'h0000);
		rd(ADDR_DIAG, 16'h0000);
		$display("t_reset done");
	endtask : t_reset

	task automatic t_page;
		host.send(16'h8002, 8'h10);
		chk("page", 32'h2, {16'h0, page_select});
		rd(ADDR_PAGE_LO, 16'h0002);
		rd(ADDR_CNT, 16'h0000);
		// Flag raised while away must survive reads from the other page
		@(negedge clk);
		ev = 10'h001;
		@(negedge clk);
		ev = 10'h000;
		rd(ADDR_ERR, 16'h0000);
		host.send(16'h8101, 8'h20);
		chk("page", 32'h0102, {16'h0, page_select});
		host.send(16'h8100, 8'h10);
		host.send(16'h8000, 8'h10);
		chk("page", 32'h0, {16'h0, page_select});
		rd(ADDR_ERR, 16'h8000);
		rd(ADDR_ERR, 16'h0000);
		$display("t_page done");
	endtask : t_page

	task automatic t_sample;
		@(negedge clk);
		gyro_x = 32'h4e200001;
		gyro_y = 32'hfffffffe;
		temp_in = 16'hee3a;
		sample_update = 1'b1;
		@(negedge clk);
		sample_update = 1'b0;
		rd(ADDR_CNT, 16'h0001);
		rd(ADDR_GXH, 16'h4e20);
		rd(ADDR_GXL, 16'h0001);
		rd(ADDR_GYH, 16'hffff);
		rd(ADDR_GYL, 16'hfffe);
		rd(ADDR_TEMP, 16'hee3a);
		@(negedge clk);
		sample_update = 1'b1;
		repeat (65535) @(negedge clk);
		sample_update = 1'b0;
		rd(ADDR_CNT, 16'h0000);
		$display("t_sample done");
	endtask : t_sample

	task automatic t_err;
		e(10'h001, 16'h0000, 16'h8000);
		e(10'h002, 16'h0000, 16'h0000);
		e(10'h002, 16'h0100, 16'h0100);
		e(10'h008, 16'h0000, 16'h0040);
		e(10'h018, 16'h0000, 16'h0000);
		e(10'h060, 16'h0000, 16'h0020);
		e(10'h020, 16'h0000, 16'h0000);
		e(10'h180, 16'h0000, 16'h0004);
		e(10'h080, 16'h0000, 16'h0000);
		e(10'h200, 16'h0000, 16'h0002);
		chk("boot", 32'h1, {31'h0, boot_from_backup});
		host.send(16'h0800, 8'h0f);
		chk("rd_valid", 32'h0, {31'h0, rd_valid});
		rd(ADDR_ERR, 16'h0008);
		rd(ADDR_ERR, 16'h0000);
		@(negedge clk);
		diag_fail = 6'h3f;
		rd(ADDR_DIAG, 16'h003f);
		rd(ADDR_DIAG, 16'h003f);
		diag_fail = 6'h05;
		rd(ADDR_DIAG, 16'h003f);
		diag_fail = 6'h00;
		rd(ADDR_DIAG, 16'h0005);
		rd(ADDR_DIAG, 16'h0000);
		e(10'h004, 16'h0000, 16'h0080);
		$display("t_err done");
	endtask : t_err

	task automatic t_crc;
		n = 0;
		while (crc_check_start !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		n = 0;
		@(negedge clk);
		while (crc_check_start !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		chk("crc period", 32'd49, n);
		$display("t_crc done");
	endtask : t_crc

	task automatic t_rst;
		host.send(16'h8002, 8'h10);
		@(negedge clk);
		sample_update = 1'b1;
		@(negedge clk);
		sample_update = 1'b0;
		rst = 1'b1;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		chk("page", 32'h0, {16'h0, page_select});
		chk("boot", 32'h0, {31'h0, boot_from_backup});
		rd(ADDR_ERR, 16'h0000);
		rd(ADDR_CNT, 16'h0000);
		$display("t_rst done");
	endtask : t_rst

	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_page();
		t_sample();
		t_crc();
		t_err();
		t_rst();
		results();
	end
endmodule : tb
